/* File: bench/nss_ctrl_tb.sv */
// Self-checking bench for the host flash controller against a flash model.
// Assumes nss_pkg is compiled and nss_map.svh is on the include path.
`timescale 1ns/1ps
`include "nss_map.svh"
module nss_ctrl_tb;
  localparam logic [7:0] MAKER  = 8'h5a; // Arbitrary value
  localparam logic [7:0] DEVICE = 8'h3c; // Arbitrary value
  logic        clk = 1'b0;
  logic        sysRst;
  logic [7:0]  regAddr;
  logic [31:0] regWrData;
  logic        regWrStb;
  logic        regRdStb;
  logic [31:0] regRdData;
  logic        ceN, cle, ale, weN, readStrobeN, ioOeN, rbN;
  logic [15:0] ioOut, ioIn, markWord;
  logic        wideBus, wpOk, failBit, holdBusy, powerUp;
  int          errCount = 0;
  int          checkCount = 0;
  int          weFalls = 0;

  nss_ctrl #(.PROG_TMO_CYC(40), .ERASE_TMO_CYC(80)) dut (
    .clk(clk), .sys_rst(sysRst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .ceN(ceN),
    .cle(cle), .ale(ale), .weN(weN), .read_strobe_n(readStrobeN), .ioOut(ioOut),
    .ioOeN(ioOeN), .ioIn(ioIn), .rbN(rbN));
  nss_flash_model #(.MAKER_ID(MAKER), .DEVICE_ID(DEVICE)) flash (
    .ceN(ceN), .cle(cle), .weN(weN), .reN(readStrobeN), .ioOut(ioOut), .ioOeN(ioOeN),
    .ioIn(ioIn), .rbN(rbN), .wide(wideBus), .wpOk(wpOk), .failBit(failBit),
    .holdBusy(holdBusy), .powerUp(powerUp), .markWord(markWord));

  initial forever #2 clk = ~clk;
  always @(negedge weN) weFalls++;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      errCount++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge clk);
    regWrStb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge clk);
    regRdStb <= 1'b0;
    #1 d = regRdData;
  endtask
  task automatic cfg(input logic [7:0] code, input logic wide, input logic hold);
    wr(`NSS_REG_CFG, {22'h0, hold, wide, code});
  endtask
  // Busy is polled, not waited on blindly, so slow device answers still pass
  task automatic waitOp(output int cyc);
    logic [31:0] s;
    cyc = 0;
    repeat (3) @(posedge clk);
    do begin
      rd(`NSS_REG_STAT, s);
      cyc += 2;
    end while (s[`NSS_ST_BUSY] !== 1'b0 && cyc < 4000);
    check("operation finished", s[`NSS_ST_BUSY], 1'b0);
  endtask
  task automatic runOp(input logic [31:0] ctl);
    int c;
    wr(`NSS_REG_CTRL, ctl);
    waitOp(c);
  endtask
  task automatic pulsePowerUp();
    powerUp <= 1'b1;
    @(posedge clk);
    powerUp <= 1'b0;
  endtask

  task automatic testReset();
    logic [31:0] s;
    check("idle pins", {ceN, cle, ale, weN, readStrobeN, ioOeN}, 6'b100111);
    rd(`NSS_REG_CFG, s);
    check("config reset", s, 32'h0);
    rd(8'h20, s);
    check("unmapped read", s, 32'h0);
  endtask
  task automatic testEraseGuard(input logic allowed);
    logic [31:0] s;
    int n;
    cfg(8'h60, 1'b0, 1'b0);
    wr(`NSS_REG_STAT, 32'h3e);
    n = weFalls;
    runOp(32'h9);
    rd(`NSS_REG_STAT, s);
    check("erase refused", s[`NSS_ST_REFUSED], !allowed);
    check("erase strobes", weFalls - n, allowed);
  endtask
  task automatic testStatus();
    logic [31:0] s;
    for (int i = 0; i < 5; i++) begin
      wpOk <= i[1];
      failBit <= i[0] | i[2];
      holdBusy <= i[2];
      cfg(8'h70, 1'b0, 1'b0);
      wr(`NSS_REG_STAT, 32'h3e);
      runOp(32'h1);
      rd(`NSS_REG_STAT, s);
      check("ready bits", s[14:13], {2{~i[2]}});
      check("protect bit", s[15], i[1]);
      check("error bit", s[8], i[0] | i[2]);
      check("masked bits", s[12:9], 4'h0);
      check("new bad block", s[`NSS_ST_NEWBAD], i[0]);
    end
    holdBusy <= 1'b0;
    wpOk <= 1'b1;
  endtask
  task automatic testSignature();
    logic [31:0] s;
    for (int w = 0; w < 2; w++) begin
      wideBus <= w[0];
      cfg(8'h00, w[0], 1'b0);
      runOp(32'h2);
      rd(`NSS_REG_IDS, s);
      check("signature words", s, {8'h00, DEVICE, 8'h00, MAKER});
    end
  endtask
  task automatic testMark();
    logic [31:0] s;
    logic [15:0] mk [4] = '{16'h00ff, 16'hff00, 16'h00ff, 16'hffff};
    for (int i = 0; i < 4; i++) begin
      wideBus <= i[1];
      markWord <= mk[i];
      cfg(8'h00, i[1], 1'b1);
      wr(`NSS_REG_STAT, 32'h3e);
      pulsePowerUp();
      runOp(32'h4);
      rd(`NSS_REG_STAT, s);
      check("bad marker", s[`NSS_ST_BADMARK], i[0] ^ i[1]);
      check("markers scanned", s[`NSS_ST_SCANNED], 1'b1);
    end
  endtask
  task automatic testStream();
    logic [31:0] s;
    logic [15:0] exp [5] = '{16'hffff, 16'h0001, 16'h0002, 16'h0003, 16'h0010};
    wideBus <= 1'b1;
    markWord <= 16'hffff;
    cfg(8'h00, 1'b1, 1'b1);
    pulsePowerUp();
    repeat (4) @(posedge clk);
    rd(`NSS_REG_STAT, s);
    check("ready after power-up", s[`NSS_ST_RBREADY], 1'b0);
    for (int k = 0; k < 5; k++) begin
      runOp(32'h3);
      rd(`NSS_REG_DATA, s);
      check("stream word", s[15:0], exp[k]);
    end
    runOp(32'h7);
    rd(`NSS_REG_CFG, s);
    check("hold dropped", s[`NSS_CFG_CEHOLD], 1'b0);
    check("chip deselected", ceN, 1'b1);
  endtask
  task automatic testWaits();
    logic [31:0] s;
    int c;
    holdBusy <= 1'b1;
    wr(`NSS_REG_STAT, 32'h3e);
    wr(`NSS_REG_CTRL, 32'h5);
    waitOp(c);
    rd(`NSS_REG_STAT, s);
    check("program timeout", s[`NSS_ST_TMO], 1'b1);
    check("timeout span", c >= 36 && c <= 64, 1'b1);
    wr(`NSS_REG_STAT, 32'h3e);
    wr(`NSS_REG_CTRL, 32'h6);
    wr(`NSS_REG_CTRL, 32'h1);
    repeat (20) @(posedge clk);
    holdBusy <= 1'b0;
    waitOp(c);
    rd(`NSS_REG_STAT, s);
    check("erase wait result", s[3:1], 3'b101);
  endtask

  task automatic finishTest();
    $display("checks %0d mismatches %0d", checkCount, errCount);
    if (errCount == 0 && checkCount > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    errCount++;
    finishTest();
  end
  initial begin
    sysRst = 1'b1;
    regAddr = 8'h00;
    regWrData = 32'h0;
    regWrStb = 1'b0;
    regRdStb = 1'b0;
    wideBus = 1'b0;
    wpOk = 1'b1;
    failBit = 1'b0;
    holdBusy = 1'b0;
    powerUp = 1'b0;
    markWord = 16'hffff;
    repeat (3) @(posedge clk);
    sysRst <= 1'b0;
    testReset();
    testEraseGuard(1'b0);
    testStatus();
    testSignature();
    testMark();
    testEraseGuard(1'b1);
    testStream();
    testWaits();
    finishTest();
  end
endmodule

/* File: bench/nss_flash_model.sv */
// Behavioural flash device: status byte, signature and power-up page stream.
// Assumes pins come straight from the controller; io level is resolved here.
`timescale 1ns/1ps
module nss_flash_model #(
  parameter int         PAGE_WORDS = 4,
  parameter int         LOAD_NS    = 200,
  parameter bit         SEQ        = 1'b1,
  parameter logic [7:0] STATUS_CMD = 8'h70,
  parameter logic [7:0] MAKER_ID   = 8'h5a, // Arbitrary value
  parameter logic [7:0] DEVICE_ID  = 8'h3c  // Arbitrary value
) (
  // Controller pins
  input  wire logic        ceN,
  input  wire logic        cle,
  input  wire logic        weN,
  input  wire logic        reN,
  input  wire logic [15:0] ioOut,
  input  wire logic        ioOeN,
  output logic [15:0]      ioIn,
  output logic             rbN,
  // Bench knobs
  input  wire logic        wide,
  input  wire logic        wpOk,
  input  wire logic        failBit,
  input  wire logic        holdBusy,
  input  wire logic        powerUp,
  input  wire logic [15:0] markWord
);
  logic [1:0]  mode = 2'h0; // 0 idle, 1 status, 2 signature, 3 page read
  logic        loading = 1'b0;
  logic        sigIdx = 1'b0;
  logic [3:0]  page = 4'h0;
  logic [3:0]  word = 4'h0;
  logic [15:0] lastIo = 16'h0000;
  logic [15:0] dOut;
  logic        rdy;
  event        loadEv;

  assign rdy = !(loading || holdBusy);
  assign rbN = rdy;
  always_comb begin
    case (mode)
      2'h1: dOut = {8'h00, wpOk, rdy, rdy,
                    3'b111, 1'b1, failBit};
      2'h2: dOut = {8'h00, sigIdx ? DEVICE_ID : MAKER_ID};
      default: dOut = (page == 4'h0 && word == 4'h0) ? markWord : {8'h00, page, word};
    endcase
    if (!wide) begin
      dOut[15:8] = ~lastIo[15:8];
    end
  end
  // Released lines show the inverse of the last value so stale data never matches
  always_comb begin
    if (!ioOeN) begin
      ioIn = ioOut;
    end else if (!ceN && !reN && mode != 2'h0 && !loading) begin
      ioIn = dOut;
    end else begin
      ioIn = ~lastIo;
    end
  end
  always @(posedge powerUp) begin
    mode = 2'h3;
    page = 4'h0;
    word = 4'h0;
    ->loadEv;
  end
  always begin
    @(loadEv);
    loading = 1'b1;
    #(LOAD_NS) loading = 1'b0;
  end
  always @(posedge weN) begin
    if (cle && !ceN) begin
      mode = ioOut[7:0] == STATUS_CMD ? 2'h1 : (ioOut[7:0] == 8'h90 ? 2'h2 : 2'h0);
      sigIdx = 1'b0;
    end
  end
  always @(posedge ceN) begin
    if (mode == 2'h3) begin
      mode = 2'h0;
    end
  end
  always @(posedge reN) begin
    if (!ceN) begin
      lastIo <= dOut;
      if (mode == 2'h2) begin
        sigIdx = ~sigIdx;
      end
      if (mode == 2'h3) begin
        word = word + 4'h1;
        if (word == PAGE_WORDS[3:0]) begin
          word = 4'h0;
          page = page + 4'h1;
          if (SEQ) begin
            ->loadEv;
          end else begin
            mode = 2'h0;
          end
        end
      end
    end
  end
endmodule

/* File: common/nss_map.svh */
// Register offsets, field positions, reset values and timing counts of the
// host-side flash controller. Assumes a 250 MHz system clock.
`ifndef NSS_MAP_SVH
`define NSS_MAP_SVH

// Software register byte addresses
`define NSS_REG_CTRL      8'h00
`define NSS_REG_CFG       8'h04
`define NSS_REG_STAT      8'h08
`define NSS_REG_DATA      8'h0c
`define NSS_REG_IDS       8'h10

// Control register fields
`define NSS_CTRL_OP_HI    2
`define NSS_CTRL_ERASE    3

// Configuration register fields and reset value
`define NSS_CFG_WIDE      8
`define NSS_CFG_CEHOLD    9
`define NSS_CFG_RST       10'h000

// Status register bits; bits one to five are sticky (write one to clear)
`define NSS_ST_BUSY       0
`define NSS_ST_DONE       1
`define NSS_ST_TMO        2
`define NSS_ST_REFUSED    3
`define NSS_ST_BADMARK    4
`define NSS_ST_NEWBAD     5
`define NSS_ST_SCANNED    6
`define NSS_ST_RBREADY    7

// Device status byte bits
`define NSS_SR_PROTECT    7
`define NSS_SR_READY_P    6
`define NSS_SR_READY_S    5
`define NSS_SR_FAIL       0
`define NSS_SR_KEEP       8'he1

// Command codes and blank values
`define NSS_CMD_SIGNATURE 8'h90
`define NSS_BLANK_BYTE    8'hff
`define NSS_BLANK_WORD    16'hffff

// Timing
`define NSS_CLK_MHZ       250
`define NSS_STROBE_NS     32
`define NSS_STROBE_CYC    ((`NSS_STROBE_NS * `NSS_CLK_MHZ + 999) / 1000)
`define NSS_CE_HIGH_NS    100
`define NSS_CE_HIGH_CYC   ((`NSS_CE_HIGH_NS * `NSS_CLK_MHZ + 999) / 1000)
`define NSS_PROG_MAX_US   500
`define NSS_ERASE_MAX_MS  3

`endif

/* File: common/nss_pkg.sv */
// Types shared by the host-side flash controller files.
// Assumes nothing beyond the map header for numbers.
package nss_pkg;
  typedef enum logic [2:0] {
    OP_NONE, OP_CMD, OP_SIG, OP_STREAM, OP_MARK, OP_WPROG, OP_WERASE, OP_ABORT
  } nss_op_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_CMD, ST_CMD_W, ST_RD, ST_RD_W, ST_WAIT, ST_CEHI
  } nss_st_t;

  typedef enum logic [1:0] {
    B_IDLE, B_LOW, B_HIGH
  } nss_bus_st_t;
endpackage

/* File: logic/nss_bus_cycle.sv */
// One asynchronous bus cycle on the flash pins: a write strobe or a read strobe.
// Assumes ioIn is already synchronised to clk by the caller.
`timescale 1ns/1ps
`include "nss_map.svh"
module nss_bus_cycle
  import nss_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Request side
  input  wire logic        start,
  input  wire logic        isWrite,
  input  wire logic [15:0] wrData,
  output logic             done,
  output logic [15:0]      rdData,
  // Pin side
  output logic             weN,
  output logic             reN,
  output logic [15:0]      ioOut,
  output logic             ioOeN,
  input  wire logic [15:0] ioIn
);
  localparam logic [3:0] LAST = 4'(`NSS_STROBE_CYC - 1);

  nss_bus_st_t st_ff, nxt_st;
  logic [3:0]  cnt_ff, nxt_cnt;
  logic        wr_ff, nxt_wr;
  logic [15:0] ioOut_ff, nxt_ioOut;
  logic [15:0] rdData_ff, nxt_rdData;

  always_comb begin
    nxt_st     = st_ff;
    nxt_cnt    = cnt_ff;
    nxt_wr     = wr_ff;
    nxt_ioOut  = ioOut_ff;
    nxt_rdData = rdData_ff;
    case (st_ff)
      B_IDLE: begin
        if (start) begin
          nxt_st    = B_LOW;
          nxt_cnt   = 4'h0;
          nxt_wr    = isWrite;
          nxt_ioOut = wrData;
        end
      end
      B_LOW: begin
        nxt_cnt = cnt_ff + 4'h1;
        if (cnt_ff == LAST) begin
          // Sample late in the pulse; the synchroniser lag stays inside it
          if (!wr_ff) begin
            nxt_rdData = ioIn;
          end
          nxt_st  = B_HIGH;
          nxt_cnt = 4'h0;
        end
      end
      B_HIGH: begin
        nxt_cnt = cnt_ff + 4'h1;
        if (cnt_ff == LAST) begin
          nxt_st = B_IDLE;
        end
      end
      default: nxt_st = B_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff     <= B_IDLE;
      cnt_ff    <= 4'h0;
      wr_ff     <= 1'b0;
      ioOut_ff  <= 16'h0000;
      rdData_ff <= 16'h0000;
    end else begin
      st_ff     <= nxt_st;
      cnt_ff    <= nxt_cnt;
      wr_ff     <= nxt_wr;
      ioOut_ff  <= nxt_ioOut;
      rdData_ff <= nxt_rdData;
    end
  end

  assign done   = (st_ff == B_HIGH) && (cnt_ff == LAST);
  assign rdData = rdData_ff;
  assign ioOut  = ioOut_ff;
  // Data held through the high phase as well, for hold time after the edge
  assign ioOeN  = !(wr_ff && (st_ff != B_IDLE));
  assign weN    = !(wr_ff && (st_ff == B_LOW));
  assign reN    = !(!wr_ff && (st_ff == B_LOW));

  property p_re_pulse;
    @(posedge clk) disable iff (sys_rst)
      $fell(reN) |-> (!reN) [*8] ##1 reN;
  endproperty
  a_re_pulse: assert property (p_re_pulse) else $error("read strobe width wrong");
endmodule

/* File: logic/nss_ctrl.sv */
// Host controller for an asynchronous NAND flash: command, status, signature,
// boot stream, marker check, busy wait with timeout and chip-select abort.
// Assumes pins are external and asynchronous; software uses a plain reg port.
// Contract
// - Status bits four to two are reserved; host ignores them.
// - Host writes signature command 90h in one write cycle before reads.
// - After ready host pulses read strobe once per word.
// - Chip select high or any command stops the sequential read.
// - Block is bad when its spare marker does not read FFh.
// - Host reads bad-block markers before any erase.
// - Status error after program or erase marks a newly bad block.
// - Busy timeout allows 500 us program and 3 ms erase.
//
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`include "nss_map.svh"
module nss_ctrl
  import nss_pkg::*;
#(
  parameter int PROG_TMO_CYC  = `NSS_PROG_MAX_US * `NSS_CLK_MHZ,
  parameter int ERASE_TMO_CYC = `NSS_ERASE_MAX_MS * 1000 * `NSS_CLK_MHZ
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Software register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWrStb,
  input  wire logic        regRdStb,
  output logic [31:0]      regRdData,
  // Flash pins
  output logic             ceN,
  output logic             cle,
  output logic             ale,
  output logic             weN,
  output logic             read_strobe_n,
  output logic [15:0]      ioOut,
  output logic             ioOeN,
  input  wire logic [15:0] ioIn,
  input  wire logic        rbN
);
  localparam logic [7:0] CE_LAST = 8'(`NSS_CE_HIGH_CYC - 1);

  // Pin synchronisers
  logic [15:0] ioMeta_ff, ioSync_ff;
  logic        rbMeta_ff, rbSync_ff;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ioMeta_ff <= 16'h0000;
      ioSync_ff <= 16'h0000;
      rbMeta_ff <= 1'b0;
      rbSync_ff <= 1'b0;
    end else begin
      ioMeta_ff <= ioIn;
      ioSync_ff <= ioMeta_ff;
      rbMeta_ff <= rbN;
      rbSync_ff <= rbMeta_ff;
    end
  end
  logic rbReady;
  assign rbReady = rbSync_ff;

  // Bus cycle engine
  logic        busStart, busWrite, busDone;
  logic [15:0] busWrData, busRd;
  nss_bus_cycle u_bus (
    .clk     (clk),
    .sys_rst (sys_rst),
    .start   (busStart),
    .isWrite (busWrite),
    .wrData  (busWrData),
    .done    (busDone),
    .rdData  (busRd),
    .weN     (weN),
    .reN     (read_strobe_n),
    .ioOut   (ioOut),
    .ioOeN   (ioOeN),
    .ioIn    (ioSync_ff)
  );

  nss_st_t     st_ff, nxt_st;
  nss_op_t     op_ff, nxt_op;
  logic        erase_ff, nxt_erase;
  logic [9:0]  cfg_ff, nxt_cfg;
  logic [7:0]  cmdByte_ff, nxt_cmdByte;
  logic [1:0]  rdLeft_ff, nxt_rdLeft;
  logic [19:0] cnt_ff, nxt_cnt;
  logic [19:0] limit_ff, nxt_limit;
  logic [7:0]  sflags_ff, nxt_sflags;
  logic [15:0] data_ff, nxt_data;
  logic [15:0] maker_ff, nxt_maker;
  logic [15:0] devCode_ff, nxt_devCode;
  logic [5:1]  sticky_ff, nxt_sticky;
  logic        scanned_ff, nxt_scanned;
  logic [31:0] rdData_ff, nxt_rdData;

  logic        wide, ctrlWr, opBusy, markBlank;
  logic [15:0] rdWord;
  logic [5:1]  setBits, clrBits;
  nss_op_t     reqOp;

  assign wide      = cfg_ff[`NSS_CFG_WIDE];
  assign ctrlWr    = regWrStb && (regAddr == `NSS_REG_CTRL);
  assign reqOp     = nss_op_t'(regWrData[`NSS_CTRL_OP_HI:0]);
  assign opBusy    = (st_ff != ST_IDLE);
  // Narrow parts return byte codes; upper byte forced to zero
  assign rdWord    = wide ? busRd : {8'h00, busRd[7:0]};
  assign markBlank = wide ? (busRd == `NSS_BLANK_WORD) : (busRd[7:0] == `NSS_BLANK_BYTE);
  assign busWrite  = (st_ff == ST_CMD);
  assign busWrData = {8'h00, cmdByte_ff};
  assign busStart  = (st_ff == ST_CMD) || ((st_ff == ST_RD) &&
                     (rbReady || ((op_ff != OP_STREAM) && (op_ff != OP_MARK))));

  always_comb begin
    nxt_st      = st_ff;
    nxt_op      = op_ff;
    nxt_erase   = erase_ff;
    nxt_cfg     = cfg_ff;
    nxt_cmdByte = cmdByte_ff;
    nxt_rdLeft  = rdLeft_ff;
    nxt_cnt     = cnt_ff;
    nxt_limit   = limit_ff;
    nxt_sflags  = sflags_ff;
    nxt_data    = data_ff;
    nxt_maker   = maker_ff;
    nxt_devCode = devCode_ff;
    nxt_scanned = scanned_ff;
    setBits     = 5'h00;
    clrBits     = 5'h00;
    if (regWrStb && (regAddr == `NSS_REG_CFG)) begin
      nxt_cfg = regWrData[9:0];
    end
    if (regWrStb && (regAddr == `NSS_REG_STAT)) begin
      clrBits = regWrData[5:1];
    end
    if (ctrlWr && opBusy) begin
      setBits[`NSS_ST_REFUSED] = 1'b1;
    end
    case (st_ff)
      ST_IDLE: begin
        if (ctrlWr) begin
          nxt_op     = reqOp;
          nxt_erase  = regWrData[`NSS_CTRL_ERASE];
          nxt_cnt    = 20'h00000;
          nxt_rdLeft = 2'h1;
          case (reqOp)
            OP_CMD: begin
              // Erase would wipe the factory markers, so a scan must come first
              if (regWrData[`NSS_CTRL_ERASE] && !scanned_ff) begin
                setBits[`NSS_ST_REFUSED] = 1'b1;
              end else begin
                nxt_cmdByte = cfg_ff[7:0];
                nxt_st      = ST_CMD;
              end
            end
            OP_SIG: begin
              nxt_cmdByte = `NSS_CMD_SIGNATURE;
              nxt_rdLeft  = 2'h2;
              nxt_st      = ST_CMD;
            end
            OP_STREAM, OP_MARK: nxt_st = ST_RD;
            OP_WPROG: begin
              nxt_limit = 20'(PROG_TMO_CYC);
              nxt_st    = ST_WAIT;
            end
            OP_WERASE: begin
              nxt_limit = 20'(ERASE_TMO_CYC);
              nxt_st    = ST_WAIT;
            end
            OP_ABORT: begin
              nxt_cfg[`NSS_CFG_CEHOLD] = 1'b0;
              nxt_st                   = ST_CEHI;
            end
            default: setBits[`NSS_ST_DONE] = 1'b1;
          endcase
        end
      end
      ST_CMD: nxt_st = ST_CMD_W;
      ST_CMD_W: begin
        if (busDone) begin
          if ((op_ff == OP_CMD) && erase_ff) begin
            nxt_st                = ST_IDLE;
            setBits[`NSS_ST_DONE] = 1'b1;
          end else begin
            nxt_st = ST_RD;
          end
        end
      end
      ST_RD: begin
        if (busStart) begin
          nxt_st = ST_RD_W;
        end
      end
      ST_RD_W: begin
        if (busDone) begin
          nxt_rdLeft = rdLeft_ff - 2'h1;
          case (op_ff)
            OP_CMD: begin
              // Reserved bits dropped so software never sees them
              nxt_sflags = busRd[7:0] & `NSS_SR_KEEP;
              if (busRd[`NSS_SR_FAIL] && busRd[`NSS_SR_READY_P]) begin
                setBits[`NSS_ST_NEWBAD] = 1'b1;
              end
            end
            OP_SIG: begin
              if (rdLeft_ff == 2'h2) begin
                nxt_maker = rdWord;
              end else begin
                nxt_devCode = rdWord;
              end
            end
            OP_MARK: begin
              nxt_scanned = 1'b1;
              nxt_data    = rdWord;
              if (!markBlank) begin
                setBits[`NSS_ST_BADMARK] = 1'b1;
              end
            end
            default: nxt_data = rdWord;
          endcase
          if (rdLeft_ff == 2'h1) begin
            nxt_st                = ST_IDLE;
            setBits[`NSS_ST_DONE] = 1'b1;
          end else begin
            nxt_st = ST_RD;
          end
        end
      end
      ST_WAIT: begin
        nxt_cnt = cnt_ff + 20'h00001;
        if (rbReady) begin
          nxt_st                = ST_IDLE;
          setBits[`NSS_ST_DONE] = 1'b1;
        end else if (cnt_ff == limit_ff) begin
          nxt_st               = ST_IDLE;
          setBits[`NSS_ST_TMO] = 1'b1;
        end
      end
      ST_CEHI: begin
        // Chip select held high long enough to end the sequential read
        nxt_cnt = cnt_ff + 20'h00001;
        if (cnt_ff[7:0] == CE_LAST) begin
          nxt_st                = ST_IDLE;
          setBits[`NSS_ST_DONE] = 1'b1;
        end
      end
      default: nxt_st = ST_IDLE;
    endcase
    // A hardware set in the clearing cycle wins
    nxt_sticky = (sticky_ff & ~clrBits) | setBits;
    nxt_rdData = 32'h00000000;
    if (regRdStb) begin
      case (regAddr)
        `NSS_REG_CTRL: nxt_rdData = {25'h0, erase_ff, 3'(op_ff), 3'h0};
        `NSS_REG_CFG:  nxt_rdData = {22'h0, cfg_ff};
        `NSS_REG_STAT: nxt_rdData = {16'h0, sflags_ff, rbReady, scanned_ff, sticky_ff, opBusy};
        `NSS_REG_DATA: nxt_rdData = {16'h0, data_ff};
        `NSS_REG_IDS:  nxt_rdData = {devCode_ff, maker_ff};
        default:       nxt_rdData = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff      <= ST_IDLE;
      op_ff      <= OP_NONE;
      erase_ff   <= 1'b0;
      cfg_ff     <= `NSS_CFG_RST;
      cmdByte_ff <= 8'h00;
      rdLeft_ff  <= 2'h0;
      cnt_ff     <= 20'h00000;
      limit_ff   <= 20'h00000;
      sflags_ff  <= 8'h00;
      data_ff    <= 16'h0000;
      maker_ff   <= 16'h0000;
      devCode_ff <= 16'h0000;
      sticky_ff  <= 5'h00;
      scanned_ff <= 1'b0;
      rdData_ff  <= 32'h00000000;
    end else begin
      st_ff      <= nxt_st;
      op_ff      <= nxt_op;
      erase_ff   <= nxt_erase;
      cfg_ff     <= nxt_cfg;
      cmdByte_ff <= nxt_cmdByte;
      rdLeft_ff  <= nxt_rdLeft;
      cnt_ff     <= nxt_cnt;
      limit_ff   <= nxt_limit;
      sflags_ff  <= nxt_sflags;
      data_ff    <= nxt_data;
      maker_ff   <= nxt_maker;
      devCode_ff <= nxt_devCode;
      sticky_ff  <= nxt_sticky;
      scanned_ff <= nxt_scanned;
      rdData_ff  <= nxt_rdData;
    end
  end

  assign regRdData = rdData_ff;
  assign ceN       = (st_ff == ST_CEHI) || !(cfg_ff[`NSS_CFG_CEHOLD] || opBusy);
  assign cle       = (st_ff == ST_CMD) || (st_ff == ST_CMD_W);
  assign ale       = 1'b0;

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_ce_high;
    ceN [*8];
  endsequence
  property p_sig_code;
    (busStart && busWrite && (op_ff == OP_SIG)) |-> (busWrData[7:0] == 8'h90) && cle;
  endproperty
  a_sig_code: assert property (p_sig_code) else $error("signature code wrong");
  property p_stream_ready;
    (busStart && !busWrite && ((op_ff == OP_STREAM) || (op_ff == OP_MARK))) |-> rbReady;
  endproperty
  a_stream_ready: assert property (p_stream_ready) else $error("strobe while busy");
  property p_abort_ce;
    (st_ff == ST_CEHI) && ($past(st_ff) != ST_CEHI) |-> s_ce_high;
  endproperty
  a_abort_ce: assert property (p_abort_ce) else $error("chip select not held high");
  property p_mark_bad;
    ((st_ff == ST_RD_W) && busDone && (op_ff == OP_MARK) && !markBlank)
      |=> sticky_ff[`NSS_ST_BADMARK] && scanned_ff;
  endproperty
  a_mark_bad: assert property (p_mark_bad) else $error("bad marker missed");
  property p_erase_guard;
    (ctrlWr && !opBusy && (reqOp == OP_CMD) && regWrData[`NSS_CTRL_ERASE] && !scanned_ff)
      |=> (st_ff == ST_IDLE) && sticky_ff[`NSS_ST_REFUSED];
  endproperty
  a_erase_guard: assert property (p_erase_guard) else $error("erase before scan");
  property p_new_bad;
    ((st_ff == ST_RD_W) && busDone && (op_ff == OP_CMD) && busRd[0] && busRd[6])
      |=> sticky_ff[`NSS_ST_NEWBAD];
  endproperty
  a_new_bad: assert property (p_new_bad) else $error("new bad block missed");
  property p_timeout;
    ((st_ff == ST_WAIT) && !rbReady && (cnt_ff == limit_ff))
      |=> (st_ff == ST_IDLE) && sticky_ff[`NSS_ST_TMO];
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout not raised");
  property p_reserved;
    sflags_ff[4:2] == 3'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved status bits kept");
endmodule
